/* rtl/ptp_pkg.sv */
package ptp_pkg;
  localparam int APB_AW = 8;
  localparam int APB_DW = 32;

  // register indices; byte address is index times four
  localparam logic [3:0] IDX_SHORT_CTL  = 4'h0;
  localparam logic [3:0] IDX_SHARED_CTL = 4'h1;
  localparam logic [3:0] IDX_LONG_CTL   = 4'h2;
  localparam logic [3:0] IDX_SYNC_CTL   = 4'h3;
  localparam logic [3:0] IDX_SHORT_INIT = 4'h4;
  localparam logic [3:0] IDX_LONG_INIT  = 4'h5;

  // per-timer control fields
  localparam int BIT_ENABLE   = 7;
  localparam int BIT_SINGLE   = 6;
  localparam int BIT_TIMEOUT  = 5;
  localparam int BIT_INT_MASK = 1;
  localparam int BIT_PIN_OUT  = 0;

  // shared control fields
  localparam int BIT_MODE     = 7;
  localparam int BIT_COMB_OUT = 6;
  localparam int BIT_FUNC_HI  = 5;
  localparam int BIT_FUNC_LO  = 4;
  localparam int BIT_SUB_HI   = 3;
  localparam int BIT_SUB_LO   = 2;
  localparam int BIT_INIT_S   = 1;
  localparam int BIT_INIT_L   = 0;

  // sync register fields
  localparam int BIT_LONG_EN  = 7;
  localparam int BIT_SHORT_EN = 6;
  localparam int BIT_SYNC     = 5;
  localparam logic [4:0] SYNC_LOW_READ = 5'h1F;

  localparam logic [7:0] CTL_RESET    = 8'h00;
  localparam logic [7:0] CTL_STORE    = 8'h5F;

  typedef enum logic [1:0] {
    PTP_SUB_NORMAL = 2'b00,
    PTP_SUB_PINGPONG = 2'b01,
    PTP_SUB_LONG_LOW = 2'b10,
    PTP_SUB_LONG_HIGH = 2'b11
  } ptp_sub_t;

  typedef enum logic [1:0] {
    PTP_FN_AND  = 2'b00,
    PTP_FN_OR   = 2'b01,
    PTP_FN_NOR  = 2'b10,
    PTP_FN_NAND = 2'b11
  } ptp_func_t;

  typedef struct packed {
    logic              psel;
    logic              penable;
    logic              pwrite;
    logic [APB_AW-1:0] paddr;
    logic [APB_DW-1:0] pwdata;
  } ptp_apb_req_t;

  typedef struct packed {
    logic              pready;
    logic              pslverr;
    logic [APB_DW-1:0] prdata;
  } ptp_apb_rsp_t;

  typedef struct packed {
    logic short_data;
    logic long_data;
    logic comb_data;
  } ptp_port_t;
endpackage

/* rtl/ptp_timer.sv */
`timescale 1ns/10ps
module ptp_timer #(
  parameter int W = 8
) (
  input  wire logic         mclk,
  input  wire logic         reset,
  input  wire logic         ce,
  input  wire logic         load,
  input  wire logic         run,
  input  wire logic [W-1:0] reload,
  input  wire logic         init_level,
  output logic              tc,
  output logic              tout
);
  logic [W-1:0] cnt;
  logic [W-1:0] next_cnt;
  logic         next_tc;
  logic         next_tout;

  // a load always wins, so a restart never resumes an old count
  always_comb begin
    next_cnt  = cnt;
    next_tout = tout;
    next_tc   = 1'b0;
    if (load) begin
      next_cnt  = reload;
      next_tout = init_level;
    end else if (run) begin
      if (cnt == '0) begin
        next_tc   = 1'b1;
        next_tout = ~tout;
        next_cnt  = reload;
      end else begin
        next_cnt = cnt - 1'b1;
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      cnt  <= '0;
      tc   <= 1'b0;
      tout <= 1'b0;
    end else if (ce) begin
      cnt  <= next_cnt;
      tc   <= next_tc;
      tout <= next_tout;
    end
  end
endmodule

/* rtl/ptp_top.sv */
// Chosen here: the APB interface to the registers.
`timescale 1ns/10ps
module ptp_top
  import ptp_pkg::*;
#(
  parameter int SHORT_W = 8,
  parameter int LONG_W  = 16
) (
  input  wire logic                  mclk,
  input  wire logic                  reset,
  input  wire logic                  ce,
  input  wire ptp_pkg::ptp_apb_req_t apb_req,
  output ptp_pkg::ptp_apb_rsp_t      apb_rsp,
  input  wire ptp_pkg::ptp_port_t    port_data,
  output logic                       short_timer_pin,
  output logic                       long_timer_pin,
  output logic                       combined_timer_pin,
  output logic                       short_timer_irq,
  output logic                       long_timer_irq
);
  import ptp_pkg::*;

  logic [7:0]         short_ctl;
  logic [7:0]         long_ctl;
  logic [7:0]         shared_ctl;
  logic               short_en;
  logic               long_en;
  logic               sync_mode;
  logic               short_to;
  logic               long_to;
  logic [SHORT_W-1:0] short_init;
  logic [LONG_W-1:0]  long_init;
  logic               short_start;
  logic               long_start;

  logic [7:0]         next_short_ctl;
  logic [7:0]         next_long_ctl;
  logic [7:0]         next_shared_ctl;
  logic               next_short_en;
  logic               next_long_en;
  logic               next_sync_mode;
  logic               next_short_to;
  logic               next_long_to;
  logic [SHORT_W-1:0] next_short_init;
  logic [LONG_W-1:0]  next_long_init;

  ptp_apb_rsp_t       next_rsp;
  logic               next_short_pin;
  logic               next_long_pin;
  logic               next_comb_pin;
  logic               next_short_irq;
  logic               next_long_irq;

  logic               short_tc;
  logic               long_tc;
  logic               short_tout;
  logic               long_tout;

  logic [3:0]         idx;
  logic               mapped;
  logic               wr;
  logic [7:0]         wbyte;
  logic               xmit;
  ptp_sub_t           sub;
  ptp_func_t          func;
  logic               pingpong;
  logic               long_eff;
  logic [APB_DW-1:0]  rd_word;

  assign idx   = apb_req.paddr[5:2];
  assign wbyte = apb_req.pwdata[7:0];
  assign mapped = (apb_req.paddr[1:0] == 2'b00) && (apb_req.paddr[APB_AW-1:6] == '0)
                  && (idx <= IDX_LONG_INIT);
  assign wr    = apb_req.psel && apb_req.penable && apb_rsp.pready && apb_req.pwrite && mapped;
  assign xmit  = ~shared_ctl[BIT_MODE];
  assign sub   = ptp_sub_t'(shared_ctl[BIT_SUB_HI:BIT_SUB_LO]);
  assign func  = ptp_func_t'(shared_ctl[BIT_FUNC_HI:BIT_FUNC_LO]);
  assign pingpong = xmit && (sub == PTP_SUB_PINGPONG)
                    && short_ctl[BIT_SINGLE] && long_ctl[BIT_SINGLE];

  ptp_timer #(.W(SHORT_W)) u_short (
    .mclk       (mclk),
    .reset      (reset),
    .ce         (ce),
    .load       (short_start),
    .run        (short_en),
    .reload     (short_init),
    .init_level (shared_ctl[BIT_INIT_S]),
    .tc         (short_tc),
    .tout       (short_tout)
  );

  ptp_timer #(.W(LONG_W)) u_long (
    .mclk       (mclk),
    .reset      (reset),
    .ce         (ce),
    .load       (long_start),
    .run        (long_en),
    .reload     (long_init),
    .init_level (shared_ctl[BIT_INIT_L]),
    .tc         (long_tc),
    .tout       (long_tout)
  );

  // register file and enable control
  always_comb begin
    next_short_ctl  = short_ctl;
    next_long_ctl   = long_ctl;
    next_shared_ctl = shared_ctl;
    next_short_en   = short_en;
    next_long_en    = long_en;
    next_sync_mode  = sync_mode;
    next_short_init = short_init;
    next_long_init  = long_init;
    next_short_to   = short_to;
    next_long_to    = long_to;
    if (wr) begin
      case (idx)
        IDX_SHORT_CTL: begin
          next_short_ctl = wbyte & CTL_STORE;
          next_short_en  = wbyte[BIT_ENABLE];
          if (sync_mode) begin
            next_long_en = wbyte[BIT_ENABLE];
          end
          if (wbyte[BIT_TIMEOUT]) begin
            next_short_to = 1'b0;
          end
        end
        IDX_LONG_CTL: begin
          next_long_ctl = wbyte & CTL_STORE;
          next_long_en  = wbyte[BIT_ENABLE];
          if (sync_mode) begin
            next_short_en = wbyte[BIT_ENABLE];
          end
          if (wbyte[BIT_TIMEOUT]) begin
            next_long_to = 1'b0;
          end
        end
        IDX_SHARED_CTL: begin
          next_shared_ctl = wbyte;
        end
        IDX_SYNC_CTL: begin
          next_sync_mode = wbyte[BIT_SYNC];
          if (wbyte[BIT_SYNC]) begin
            // in sync mode either bit starts both, both clear stops both
            next_long_en  = wbyte[BIT_LONG_EN] | wbyte[BIT_SHORT_EN];
            next_short_en = wbyte[BIT_LONG_EN] | wbyte[BIT_SHORT_EN];
          end else begin
            next_long_en  = wbyte[BIT_LONG_EN];
            next_short_en = wbyte[BIT_SHORT_EN];
          end
        end
        IDX_SHORT_INIT: begin
          next_short_init = apb_req.pwdata[SHORT_W-1:0];
        end
        IDX_LONG_INIT: begin
          next_long_init = apb_req.pwdata[LONG_W-1:0];
        end
        default: begin
          next_sync_mode = sync_mode;
        end
      endcase
    end
    // hardware events come last so they win over a same-cycle write
    if (short_tc) begin
      next_short_to = 1'b1;
      if (pingpong) begin
        next_short_en = 1'b0;
        next_long_en  = 1'b1;
      end else if (short_ctl[BIT_SINGLE]) begin
        next_short_en = 1'b0;
      end
    end
    if (long_tc) begin
      next_long_to = 1'b1;
      if (pingpong) begin
        next_long_en  = 1'b0;
        next_short_en = 1'b1;
      end else if (long_ctl[BIT_SINGLE]) begin
        next_long_en = 1'b0;
      end
    end
  end

  // read mux and a one-wait-state APB answer
  always_comb begin
    rd_word = '0;
    case (idx)
      IDX_SHORT_CTL: begin
        rd_word[7:0] = {short_en, short_ctl[BIT_SINGLE], short_to, short_ctl[4:0]};
      end
      IDX_LONG_CTL: begin
        rd_word[7:0] = {long_en, long_ctl[BIT_SINGLE], long_to, long_ctl[4:0]};
      end
      IDX_SHARED_CTL: begin
        rd_word[7:0] = shared_ctl;
      end
      IDX_SYNC_CTL: begin
        rd_word[7:0] = {long_en, short_en, sync_mode, SYNC_LOW_READ};
      end
      IDX_SHORT_INIT: begin
        rd_word[SHORT_W-1:0] = short_init;
      end
      IDX_LONG_INIT: begin
        rd_word[LONG_W-1:0] = long_init;
      end
      default: begin
        rd_word = '0;
      end
    endcase
    next_rsp = apb_rsp;
    next_rsp.pready = apb_req.psel && apb_req.penable && !apb_rsp.pready;
    if (apb_req.psel && apb_req.penable && !apb_rsp.pready) begin
      next_rsp.prdata  = (mapped && !apb_req.pwrite) ? rd_word : '0;
      next_rsp.pslverr = !mapped;
    end else begin
      next_rsp.pslverr = 1'b0;
    end
  end

  // pin routing; the submode levels only force the long output in transmit mode
  always_comb begin
    long_eff = long_tout;
    if (xmit && (sub == PTP_SUB_LONG_LOW)) begin
      long_eff = 1'b0;
    end else if (xmit && (sub == PTP_SUB_LONG_HIGH)) begin
      long_eff = 1'b1;
    end
    next_short_pin = short_ctl[BIT_PIN_OUT] ? short_tout : port_data.short_data;
    next_long_pin  = long_ctl[BIT_PIN_OUT] ? long_eff : port_data.long_data;
    next_comb_pin  = port_data.comb_data;
    if (xmit && shared_ctl[BIT_COMB_OUT]) begin
      case (func)
        PTP_FN_AND:  next_comb_pin = short_tout & long_eff;
        PTP_FN_OR:   next_comb_pin = short_tout | long_eff;
        PTP_FN_NOR:  next_comb_pin = ~(short_tout | long_eff);
        PTP_FN_NAND: next_comb_pin = ~(short_tout & long_eff);
        default:     next_comb_pin = port_data.comb_data;
      endcase
    end
    next_short_irq = short_tc & short_ctl[BIT_INT_MASK];
    next_long_irq  = long_tc & long_ctl[BIT_INT_MASK];
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      short_ctl          <= CTL_RESET;
      long_ctl           <= CTL_RESET;
      shared_ctl         <= CTL_RESET;
      short_en           <= 1'b0;
      long_en            <= 1'b0;
      sync_mode          <= 1'b0;
      short_to           <= 1'b0;
      long_to            <= 1'b0;
      short_init         <= '0;
      long_init          <= '0;
      short_start        <= 1'b0;
      long_start         <= 1'b0;
      apb_rsp            <= '0;
      short_timer_pin    <= 1'b0;
      long_timer_pin     <= 1'b0;
      combined_timer_pin <= 1'b0;
      short_timer_irq    <= 1'b0;
      long_timer_irq     <= 1'b0;
    end else if (ce) begin
      short_ctl          <= next_short_ctl;
      long_ctl           <= next_long_ctl;
      shared_ctl         <= next_shared_ctl;
      short_en           <= next_short_en;
      long_en            <= next_long_en;
      sync_mode          <= next_sync_mode;
      short_to           <= next_short_to;
      long_to            <= next_long_to;
      short_init         <= next_short_init;
      long_init          <= next_long_init;
      short_start        <= next_short_en & ~short_en;
      long_start         <= next_long_en & ~long_en;
      apb_rsp            <= next_rsp;
      short_timer_pin    <= next_short_pin;
      long_timer_pin     <= next_long_pin;
      combined_timer_pin <= next_comb_pin;
      short_timer_irq    <= next_short_irq;
      long_timer_irq     <= next_long_irq;
    end
  end
endmodule

/* sim/ptp_top_chk.sv */
`timescale 1ns/10ps
module ptp_top_chk
  import ptp_pkg::*;
#(
  parameter int SHORT_W = 8,
  parameter int LONG_W  = 16
) (
  input wire logic                  mclk,
  input wire logic                  reset,
  input wire logic                  ce,
  input wire ptp_pkg::ptp_apb_req_t apb_req,
  input wire ptp_pkg::ptp_apb_rsp_t apb_rsp,
  input wire ptp_pkg::ptp_port_t    port_data,
  input wire logic                  short_timer_pin,
  input wire logic                  long_timer_pin,
  input wire logic                  combined_timer_pin,
  input wire logic                  short_timer_irq,
  input wire logic                  long_timer_irq
);
  // shadow of route and mask bits, so pin checks need no internal probes
  logic [3:0] shd;
  logic [3:0] next_shd;
  logic       wr;
  logic       bad;

  assign wr  = ce && apb_req.psel && apb_req.penable && apb_req.pwrite && apb_rsp.pready;
  assign bad = apb_req.paddr[1:0] != 2'h0 || apb_req.paddr > 8'h14;

  always_comb begin
    next_shd = shd;
    if (wr && apb_req.paddr == 8'h00) begin
      next_shd[1:0] = apb_req.pwdata[1:0];
    end
    if (wr && apb_req.paddr == 8'h08) begin
      next_shd[2] = apb_req.pwdata[0];
    end
    if (wr && apb_req.paddr == 8'h04) begin
      next_shd[3] = apb_req.pwdata[6] && !apb_req.pwdata[7];
    end
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      shd <= 4'h0;
    end else begin
      shd <= next_shd;
    end
  end

  default clocking dc @(posedge mclk);
  endclocking
  default disable iff (reset);

  chk_ready_wait: assert property (apb_req.psel && apb_req.penable && !apb_rsp.pready && ce
    |=> apb_rsp.pready) else $error("pready not after one wait state");
  chk_ready_pulse: assert property (apb_rsp.pready && ce |=> !apb_rsp.pready)
    else $error("pready longer than one cycle");
  chk_err_addr: assert property (apb_rsp.pready |-> apb_rsp.pslverr == bad)
    else $error("pslverr does not match address");
  chk_err_data: assert property (apb_rsp.pready && bad |-> apb_rsp.prdata == 32'h0)
    else $error("unmapped read data not zero");
  chk_sync_low: assert property (apb_rsp.pready && !apb_req.pwrite && apb_req.paddr == 8'h0C
    |-> apb_rsp.prdata[4:0] == 5'h1F && apb_rsp.prdata[31:8] == 24'h0)
    else $error("sync register fixed bits wrong");
  chk_short_route: assert property (!$past(reset) && $past(ce) && !$past(shd[0])
    |-> short_timer_pin == $past(port_data.short_data)) else $error("short pin not port");
  chk_long_route: assert property (!$past(reset) && $past(ce) && !$past(shd[2])
    |-> long_timer_pin == $past(port_data.long_data)) else $error("long pin not port");
  chk_comb_route: assert property (!$past(reset) && $past(ce) && !$past(shd[3])
    |-> combined_timer_pin == $past(port_data.comb_data)) else $error("comb pin not port");
  chk_irq_mask: assert property (short_timer_irq |-> $past(shd[1]))
    else $error("short irq while masked");
endmodule

bind ptp_top ptp_top_chk #(.SHORT_W(SHORT_W), .LONG_W(LONG_W)) u_chk (
  .mclk(mclk), .reset(reset), .ce(ce), .apb_req(apb_req), .apb_rsp(apb_rsp),
  .port_data(port_data), .short_timer_pin(short_timer_pin), .long_timer_pin(long_timer_pin),
  .combined_timer_pin(combined_timer_pin), .short_timer_irq(short_timer_irq),
  .long_timer_irq(long_timer_irq));

/* sim/ptp_top_tb.sv */
`timescale 1ns/10ps
module ptp_top_tb;
  import ptp_pkg::*;
  logic         mclk = 1'h0;
  logic         reset = 1'h1;
  logic         ce = 1'h1;
  ptp_apb_req_t req = '0;
  ptp_apb_rsp_t rsp;
  ptp_port_t    pd = '0;
  logic         sp, lp, cp, si, li;
  logic [31:0]  rd;
  logic         er;
  int           fails = 0;
  int           total_checks = 0;

  always #20 mclk = ~mclk;

  ptp_top dut (
    .mclk(mclk), .reset(reset), .ce(ce), .apb_req(req), .apb_rsp(rsp),
    .port_data(pd), .short_timer_pin(sp), .long_timer_pin(lp),
    .combined_timer_pin(cp), .short_timer_irq(si), .long_timer_irq(li));

  task automatic end_sim;
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  task automatic cmp(input string n, input logic [31:0] e, input logic [31:0] g);
    total_checks++;
    if (g !== e) begin
      fails++;
      $display("Error %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic cmpb(input string n, input logic e, input logic g);
    cmp(n, {31'h0, e}, {31'h0, g});
  endtask

  // one idle edge after each transfer keeps psel from being driven twice in a step
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d = 32'h0);
    int n;
    n = 0;
    req <= '{1'h1, 1'h0, w, a, d};
    @(posedge mclk);
    req.penable <= 1'h1;
    do begin
      @(posedge mclk);
      n++;
    end while (rsp.pready !== 1'h1 && n < 20);
    rd = rsp.prdata;
    er = rsp.pslverr;
    req.psel <= 1'h0;
    req.penable <= 1'h0;
    @(posedge mclk);
    if (n >= 20) begin
      fails++;
      end_sim;
    end
  endtask

  task automatic rchk(input logic [7:0] a, input logic [31:0] e, input string n);
    bus(1'h0, a);
    cmp(n, e, rd);
  endtask

  // waits for one timer's irq; the other firing first is an order error
  task automatic wirq(input logic lng, output int n);
    n = 0;
    do begin
      @(posedge mclk);
      n++;
      cmpb("irq order", 1'h0, lng ? si : li);
    end while ((lng ? li : si) !== 1'h1 && n < 80);
    if (n >= 80) begin
      fails++;
      end_sim;
    end
  endtask

  task automatic t_map;
    rchk(8'h0C, 32'h1F, "sync reset");
    rchk(8'h04, 32'h0, "shared reset");
    rchk(8'h18, 32'h0, "unmapped read");
    cmpb("unmapped err", 1'h1, er);
    bus(1'h1, 8'h02, 32'hFF);
    cmpb("misaligned err", 1'h1, er);
    rchk(8'h00, 32'h0, "short ctl");
    $display("map test done");
  endtask

  task automatic t_en;
    bus(1'h1, 8'h10, 32'hF0);
    bus(1'h1, 8'h14, 32'hFFF0);
    bus(1'h1, 8'h0C, 32'hC0);
    rchk(8'h0C, 32'hDF, "both run");
    bus(1'h1, 8'h0C, 32'h40);
    rchk(8'h0C, 32'h5F, "long stop");
    bus(1'h1, 8'h0C, 32'h20);
    bus(1'h1, 8'h08, 32'h80);
    rchk(8'h0C, 32'hFF, "sync start");
    bus(1'h1, 8'h0C, 32'h0);
    $display("enable test done");
  endtask

  task automatic t_pins;
    pd <= '{1'h0, 1'h1, 1'h0};
    bus(1'h1, 8'h04, 32'h2);
    bus(1'h1, 8'h00, 32'h1);
    bus(1'h1, 8'h08, 32'h1);
    bus(1'h1, 8'h0C, 32'hC0);
    repeat (3) @(posedge mclk);
    cmpb("short pin", 1'h1, sp);
    cmpb("long pin", 1'h0, lp);
    // submode 11 forces the long output high although the timer holds it low
    bus(1'h1, 8'h04, 32'hE);
    @(posedge mclk);
    cmpb("long forced", 1'h1, lp);
    bus(1'h1, 8'h0C, 32'h0);
    $display("pin test done");
  endtask

  task automatic t_comb;
    logic e;
    for (int v = 0; v < 4; v++) begin
      bus(1'h1, 8'h04, {30'h0, v[1:0]});
      bus(1'h1, 8'h0C, 32'hC0);
      for (int f = 0; f < 4; f++) begin
        bus(1'h1, 8'h04, {24'h0, 2'h1, f[1:0], 2'h0, v[1:0]});
        repeat (2) @(posedge mclk);
        case (f)
          0: e = v[1] & v[0];
          1: e = v[1] | v[0];
          2: e = ~(v[1] | v[0]);
          default: e = ~(v[1] & v[0]);
        endcase
        cmpb("comb pin", e, cp);
      end
      bus(1'h1, 8'h0C, 32'h0);
    end
    // both timer outputs stay high here, so only the port value gives zero
    pd.comb_data <= 1'h0;
    bus(1'h1, 8'h04, 32'hC0);
    @(posedge mclk);
    cmpb("demod pin", 1'h0, cp);
    bus(1'h1, 8'h04, 32'h0);
    $display("comb test done");
  endtask

  task automatic t_pp;
    int n;
    bus(1'h1, 8'h10, 32'h3);
    bus(1'h1, 8'h14, 32'h5);
    bus(1'h1, 8'h00, 32'h42);
    bus(1'h1, 8'h08, 32'h42);
    bus(1'h1, 8'h04, 32'h4);
    bus(1'h1, 8'h00, 32'hC2);
    wirq(1'h0, n);
    wirq(1'h1, n);
    wirq(1'h0, n);
    bus(1'h1, 8'h04, 32'h0);
    repeat (20) @(posedge mclk);
    rchk(8'h0C, 32'h1F, "pp ended");
    bus(1'h0, 8'h00);
    cmpb("timeout set", 1'h1, rd[5]);
    bus(1'h1, 8'h00, 32'h42);
    bus(1'h0, 8'h00);
    cmpb("timeout kept", 1'h1, rd[5]);
    bus(1'h1, 8'h00, 32'h62);
    bus(1'h0, 8'h00);
    cmpb("timeout clr", 1'h0, rd[5]);
    $display("ping-pong test done");
  endtask

  task automatic t_reload;
    int a;
    int b;
    bus(1'h1, 8'h10, 32'h20);
    bus(1'h1, 8'h00, 32'hC2);
    wirq(1'h0, a);
    bus(1'h1, 8'h00, 32'hC2);
    bus(1'h1, 8'h00, 32'h42);
    bus(1'h1, 8'h00, 32'hC2);
    wirq(1'h0, b);
    cmp("restart count", a, b);
    $display("reload test done");
  endtask

  // a low clock enable must hold the pin although the port value moves
  task automatic t_ce;
    logic s;
    s = sp;
    ce <= 1'h0;
    pd.short_data <= ~s;
    repeat (3) @(posedge mclk);
    cmpb("frozen pin", s, sp);
    ce <= 1'h1;
    repeat (2) @(posedge mclk);
    cmpb("thawed pin", ~s, sp);
    $display("clock enable test done");
  endtask

  initial begin
    repeat (6) @(posedge mclk);
    reset <= 1'h0;
    @(posedge mclk);
    t_map;
    t_en;
    t_pins;
    t_comb;
    t_pp;
    t_reload;
    t_ce;
    end_sim;
  end
endmodule
